// *** rtl/hdssp_pkg.sv ***
/*
 * constants for the half-duplex sensor serial port: framing widths,
 * configuration register layout and timing counts at the 100 MHz core clock.
 * assumes the core clock is 100 MHz and free running.
 */
`default_nettype none

package hdssp_pkg;
    // ---------------------------------------------------------------
    // clock and framing
    // ---------------------------------------------------------------
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          BITS_PER_XFER     = 16;
    localparam logic [4:0]  LAST_BIT_CNT      = 5'h0F;
    localparam logic [4:0]  ADDR_DONE_CNT     = 5'h08;
    localparam logic [4:0]  DATA_LAST_CNT     = 5'h0F;
    localparam int          ADDR_W            = 7;
    localparam int          DATA_W            = 8;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int          TIMEOUT_MS        = 90;
    localparam int          TIMEOUT_CYC_DEF   = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          RELEASE_NS        = 160;
    localparam int          RELEASE_CYC       = RELEASE_NS / CLK_PERIOD_NS;
    localparam int          SETTLE_FRAMES     = 3;
    localparam int          FRAME_CYC_DEF     = 50000;

    // ---------------------------------------------------------------
    // configuration register
    // ---------------------------------------------------------------
    localparam logic [6:0]  CFG_ADDR          = 7'h00;
    localparam logic [6:0]  STATUS3_ADDR      = 7'h41;
    localparam logic [7:0]  CFG_RESET_VAL     = 8'h00;
    localparam int          CFG_RST_BIT       = 7;
    localparam int          CFG_PWRDN_BIT     = 6;
    localparam logic [7:0]  CFG_PWRDN_MASK    = 8'h40;
    localparam logic [7:0]  ZERO_BYTE         = 8'h00;

    // states, gray along idle -> address -> data
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b11,
        ST_HOLD = 2'b10
    } hdssp_state_e;
endpackage : hdssp_pkg

`default_nettype wire

// *** rtl/hdssp_port.sv ***
/*
 * device end of the two-wire half-duplex serial port: framing, turnaround,
 * transaction timeout, invalid-address handling and soft reset.
 * assumes the master clocks the link far slower than the core clock; all
 * pins are synchronised here. status byte id value is a plain parameter.
 */
`timescale 1ns/100ps
`default_nettype none

module hdssp_port #(
    parameter int         TIMEOUT_CYC = hdssp_pkg::TIMEOUT_CYC_DEF,
    parameter int         FRAME_CYC   = hdssp_pkg::FRAME_CYC_DEF,
    parameter logic [7:0] STATUS_ID   = 8'h5A  // arbitrary identity value
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_sclk,
    input  wire logic       i_sdio,
    output logic            o_sdio,
    output logic            o_sdio_oe_n,
    output logic [7:0]      o_config,
    output logic            o_power_down_bit,
    output logic            o_analog_valid
);
    // ---------------------------------------------------------------
    // pin synchronisers and edge detection
    // ---------------------------------------------------------------
    logic [1:0] sclk_sync_ff;
    logic [1:0] sdio_sync_ff;
    logic       sclk_prev_ff;
    logic       rise;
    logic       fall;

    // two flops per pin; only the second stage feeds logic
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_sync_ff <= 2'h3;
            sdio_sync_ff <= 2'h0;
            sclk_prev_ff <= 1'b1;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], i_sclk};
            sdio_sync_ff <= {sdio_sync_ff[0], i_sdio};
            sclk_prev_ff <= sclk_sync_ff[1];
        end
    end

    assign rise = sclk_sync_ff[1] & ~sclk_prev_ff;
    assign fall = ~sclk_sync_ff[1] & sclk_prev_ff;

    // ---------------------------------------------------------------
    // framing state
    // ---------------------------------------------------------------
    hdssp_pkg::hdssp_state_e state_ff;
    logic [4:0]  bit_cnt_ff;
    logic [7:0]  shift_ff;
    logic        dir_write_ff;
    logic [6:0]  addr_ff;
    logic [31:0] tmo_cnt_ff;
    logic        timeout;
    logic        wr_done;
    logic [7:0]  wr_byte;
    logic        soft_rst_ff;

    // timeout is frozen while powered down; a partial command then hangs
    assign timeout = (state_ff != hdssp_pkg::ST_IDLE) && (state_ff != hdssp_pkg::ST_HOLD)
                     && !o_power_down_bit
                     && (tmo_cnt_ff >= 32'(TIMEOUT_CYC));
    assign wr_byte = {shift_ff[6:0], sdio_sync_ff[1]};
    assign wr_done = rise && (state_ff == hdssp_pkg::ST_DATA) && dir_write_ff
                     && (bit_cnt_ff == hdssp_pkg::DATA_LAST_CNT);

    // bit counter and state; the master alone starts a transaction
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff     <= hdssp_pkg::ST_IDLE;
            bit_cnt_ff   <= 5'h00;
            shift_ff     <= 8'h00;
            dir_write_ff <= 1'b0;
            addr_ff      <= 7'h00;
        end else if (timeout || soft_rst_ff) begin
            state_ff   <= hdssp_pkg::ST_IDLE;
            bit_cnt_ff <= 5'h00;
        end else begin
            case (state_ff)
                hdssp_pkg::ST_IDLE, hdssp_pkg::ST_HOLD: begin
                    if (rise) begin
                        dir_write_ff <= sdio_sync_ff[1];
                        bit_cnt_ff   <= 5'h01;
                        state_ff     <= hdssp_pkg::ST_ADDR;
                    end else if (fall && state_ff == hdssp_pkg::ST_HOLD) begin
                        state_ff <= hdssp_pkg::ST_IDLE;
                    end
                end
                hdssp_pkg::ST_ADDR: begin
                    if (rise) begin
                        shift_ff   <= wr_byte;
                        bit_cnt_ff <= bit_cnt_ff + 5'h01;
                        if (bit_cnt_ff == hdssp_pkg::ADDR_DONE_CNT - 5'h01) begin
                            addr_ff  <= wr_byte[6:0];
                            state_ff <= hdssp_pkg::ST_DATA;
                        end
                    end
                end
                hdssp_pkg::ST_DATA: begin
                    if (rise) begin
                        shift_ff   <= wr_byte;
                        bit_cnt_ff <= bit_cnt_ff + 5'h01;
                        if (bit_cnt_ff == hdssp_pkg::DATA_LAST_CNT) begin
                            bit_cnt_ff <= 5'h00;
                            state_ff   <= dir_write_ff ? hdssp_pkg::ST_IDLE
                                                       : hdssp_pkg::ST_HOLD;
                        end
                    end
                end
                default: state_ff <= hdssp_pkg::ST_IDLE;
            endcase
        end
    end

    // transaction timer, runs from the first rising clock edge of a transaction
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tmo_cnt_ff <= 32'h0;
        end else if (state_ff == hdssp_pkg::ST_IDLE || state_ff == hdssp_pkg::ST_HOLD) begin
            tmo_cnt_ff <= 32'h0;
        end else if (!o_power_down_bit && !timeout) begin
            tmo_cnt_ff <= tmo_cnt_ff + 32'h1;
        end
    end

    // ---------------------------------------------------------------
    // configuration register and soft reset
    // ---------------------------------------------------------------
    // soft reset applies the written byte, then clears the reset bit itself
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_config         <= hdssp_pkg::CFG_RESET_VAL;
            o_power_down_bit <= 1'b0;
            soft_rst_ff      <= 1'b0;
        end else begin
            soft_rst_ff <= 1'b0;
            if (soft_rst_ff) begin
                o_config[hdssp_pkg::CFG_RST_BIT] <= 1'b0;
            end
            if (wr_done && addr_ff == hdssp_pkg::CFG_ADDR) begin
                if (o_power_down_bit) begin
                    o_config <= (o_config & ~hdssp_pkg::CFG_PWRDN_MASK)
                                | (wr_byte & hdssp_pkg::CFG_PWRDN_MASK);
                end else begin
                    o_config    <= wr_byte;
                    soft_rst_ff <= wr_byte[hdssp_pkg::CFG_RST_BIT];
                end
                o_power_down_bit <= wr_byte[hdssp_pkg::CFG_PWRDN_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // read data and pin drive
    // ---------------------------------------------------------------
    logic [7:0] rd_byte;
    logic [7:0] rd_shift_ff;

    // only the config and status bytes exist here; others read zero
    // decoded from the address as it lands: addr_ff loads on that same edge
    always_comb begin
        if (wr_byte[6:0] == hdssp_pkg::CFG_ADDR) begin
            rd_byte = o_config;
        end else if (wr_byte[6:0] == hdssp_pkg::STATUS3_ADDR) begin
            rd_byte = STATUS_ID;
        end else begin
            rd_byte = hdssp_pkg::ZERO_BYTE;
        end
    end

    // device drives from the rising edge that ends the address, changes on falls
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_shift_ff <= 8'h00;
            o_sdio      <= 1'b0;
            o_sdio_oe_n <= 1'b1;
        end else if (timeout || soft_rst_ff) begin
            o_sdio_oe_n <= 1'b1;
        end else if (rise && state_ff == hdssp_pkg::ST_ADDR
                     && bit_cnt_ff == hdssp_pkg::ADDR_DONE_CNT - 5'h01 && !dir_write_ff) begin
            rd_shift_ff <= rd_byte;
            o_sdio      <= rd_byte[7];
            o_sdio_oe_n <= 1'b0;
        end else if (fall && state_ff == hdssp_pkg::ST_DATA && !dir_write_ff
                     && bit_cnt_ff != hdssp_pkg::ADDR_DONE_CNT) begin
            rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
            o_sdio      <= rd_shift_ff[6];
        end else if (fall && state_ff == hdssp_pkg::ST_HOLD) begin
            o_sdio_oe_n <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // analog settle after soft reset
    // ---------------------------------------------------------------
    logic [31:0] settle_cnt_ff;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            settle_cnt_ff  <= 32'h0;
            o_analog_valid <= 1'b0;
        end else if (soft_rst_ff) begin
            settle_cnt_ff  <= 32'h0;
            o_analog_valid <= 1'b0;
        end else if (settle_cnt_ff < 32'(FRAME_CYC * hdssp_pkg::SETTLE_FRAMES)) begin
            settle_cnt_ff <= settle_cnt_ff + 32'h1;
        end else begin
            o_analog_valid <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_read_addr_done;
        rise && state_ff == hdssp_pkg::ST_ADDR
        && bit_cnt_ff == hdssp_pkg::ADDR_DONE_CNT - 5'h01 && !dir_write_ff;
    endsequence

    a_drive_after_addr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_read_addr_done ##1 !soft_rst_ff |-> !o_sdio_oe_n)
        else $error("read data not driven after address");
    a_write_no_drive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_ff == hdssp_pkg::ST_DATA && dir_write_ff) |-> o_sdio_oe_n)
        else $error("pin driven during write");
    a_hold_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (fall && state_ff == hdssp_pkg::ST_HOLD) |=> o_sdio_oe_n)
        else $error("pin not released on falling edge");
    a_hold_keeps: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_ff == hdssp_pkg::ST_HOLD && !fall && !rise) |=> $stable(o_sdio))
        else $error("final bit changed while held");
    a_release_fast: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (fall && state_ff == hdssp_pkg::ST_HOLD) |-> ##[1:2] o_sdio_oe_n)
        else $error("release slower than limit");
    a_rst_selfclear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        soft_rst_ff |=> !o_config[hdssp_pkg::CFG_RST_BIT])
        else $error("reset bit not cleared");
    a_power_down_mask: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_done && addr_ff == hdssp_pkg::CFG_ADDR && o_power_down_bit)
        |=> ((o_config & ~hdssp_pkg::CFG_PWRDN_MASK)
             == ($past(o_config) & ~hdssp_pkg::CFG_PWRDN_MASK)))
        else $error("non power-down bits changed while down");
    a_timeout_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        timeout |=> state_ff == hdssp_pkg::ST_IDLE)
        else $error("timeout did not idle port");
    a_bad_addr_keep: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_done && addr_ff != hdssp_pkg::CFG_ADDR && !soft_rst_ff) |=> $stable(o_config))
        else $error("invalid write changed state");
endmodule : hdssp_port

`default_nettype wire

// *** test/hdssp_host_model.sv ***
/*
 * host master model for the half-duplex sensor serial port: makes the link
 * clock, drives and releases the shared data line, reads returned bytes.
 * assumes the bench calls xfer from one process at a time.
 */
`timescale 1ns/100ps
`default_nettype none

module hdssp_host_model #(
    parameter int GAP_NS = 100000
) (
    input  wire logic i_dev_sdio,
    input  wire logic i_dev_oe_n,
    output var logic  o_sclk,
    output var logic  o_line
);
    // ---------------------------------------------------------------
    // line resolution
    // ---------------------------------------------------------------
    logic host_d;
    logic host_oe;
    logic last_d;
    logic wrote;

    // a floating line shows the inverse of its last level, never a stale copy
    always @* begin
        if (!i_dev_oe_n) o_line = i_dev_sdio;
        else if (host_oe) o_line = host_d;
        else o_line = ~last_d;
    end

    // remember what the device left behind when it lets go
    always @(posedge i_dev_oe_n) last_d = i_dev_sdio;

    initial begin
        o_sclk = 1'b1;
        host_oe = 1'b1;
        host_d = 1'b1;
        last_d = 1'b1;
        wrote = 1'b0;
    end

    // ---------------------------------------------------------------
    // one transaction, or its first nbits bits
    // ---------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, input int nbits = 16);
        logic [15:0] frame;
        frame = {wr, addr, wdata};
        rdata = 8'h00;
        if (wrote) #GAP_NS;
        wrote = 1'b0;
        #3.3;  // only the master opens a frame
        for (int i = 15; i >= 16 - nbits; i--) begin
            if (i == 7 && !wr) begin
                host_oe = 1'b0;
                last_d = host_d;
                #GAP_NS;
            end
            o_sclk = 1'b0;
            if (wr || i > 7) begin
                if (!i_dev_oe_n) #160;  // wait for the device to let go
                host_oe = 1'b1;
                host_d = frame[i];
            end
            #62.5;
            o_sclk = 1'b1;
            if (i < 8) rdata[i] = o_line;
            #62.5;
        end
        wrote = wr && nbits == 16;
        if (!wr) #250;
    endtask : xfer
endmodule : hdssp_host_model

`default_nettype wire

// *** test/tb_half_duplex_sensor_serial_port.sv ***
/*
 * self-checking bench for the serial port: framing, turnaround, invalid
 * addresses, timeout, soft reset and power-down.
 * assumes the host model in hdssp_host_model.sv; counts shortened by parameter.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_half_duplex_sensor_serial_port;
    // ---------------------------------------------------------------
    // set-up
    // ---------------------------------------------------------------
    // timeout must outlast the mid-read gap plus a whole frame
    localparam int         TO_CYC = 4000;
    localparam int         FR_CYC = 20;
    localparam logic [7:0] ID     = 8'hA3;  // arbitrary identity value
    localparam logic [6:0] CFG    = hdssp_pkg::CFG_ADDR;
    logic       i_clk;
    logic       i_reset_n;
    logic       sclk;
    logic       line;
    logic       dev_sdio;
    logic       dev_oe_n;
    logic       pwr_dn;
    logic       av;
    logic [7:0] cfg;
    logic [7:0] rd;
    int         err_total;
    int         compares;

    hdssp_port #(.TIMEOUT_CYC(TO_CYC), .FRAME_CYC(FR_CYC), .STATUS_ID(ID)) u_hdssp_port (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_sdio(line),
        .o_sdio(dev_sdio), .o_sdio_oe_n(dev_oe_n), .o_config(cfg),
        .o_power_down_bit(pwr_dn), .o_analog_valid(av));

    // gap shortened: the device needs no preparation time of its own
    hdssp_host_model #(.GAP_NS(20000)) u_hdssp_host_model (
        .i_dev_sdio(dev_sdio), .i_dev_oe_n(dev_oe_n), .o_sclk(sclk), .o_line(line));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // ---------------------------------------------------------------
    // shared helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_hdssp_host_model.xfer(1'b1, a, d, rd);
    endtask : wr

    // the device keeps the last bit on the line after the final rise
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        u_hdssp_host_model.xfer(1'b0, a, 8'h00, rd);
        chk("read data", exp, rd);
        chk("held bit", {7'h00, exp[0]}, {7'h00, dev_sdio});
        chk("device drives", 8'h00, {7'h00, dev_oe_n});
    endtask : rd_chk

    task automatic tally_and_finish;
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_state;
        chk("config", 8'h00, cfg);
        chk("oe_n", 8'h01, {7'h00, dev_oe_n});
        repeat (3 * FR_CYC - 4) @(posedge i_clk);
        chk("analog early", 8'h00, {7'h00, av});
        repeat (8) @(posedge i_clk);
        chk("analog", 8'h01, {7'h00, av});
    endtask : t_reset_state

    task automatic t_write_read;
        wr(CFG, 8'h01);
        chk("config", 8'h01, cfg);
        rd_chk(CFG, 8'h01);
    endtask : t_write_read

    // the write after a read also shows the device letting go in time
    task automatic t_invalid;
        fork
            wr(7'h77, 8'hFF);
            begin
                #165;
                chk("released", 8'h01, {7'h00, dev_oe_n});
            end
        join
        chk("config kept", 8'h01, cfg);
        chk("line free", 8'h01, {7'h00, dev_oe_n});
        rd_chk(7'h05, 8'h00);
        rd_chk(hdssp_pkg::STATUS3_ADDR, ID);
    endtask : t_invalid

    task automatic t_soft_reset;
        wr(CFG, 8'h81);
        chk("reset bit", 8'h01, cfg);
        chk("analog drop", 8'h00, {7'h00, av});
        repeat (3 * FR_CYC + 8) @(posedge i_clk);
        chk("analog back", 8'h01, {7'h00, av});
    endtask : t_soft_reset

    // a stalled partial frame must not swallow the next write
    task automatic t_timeout;
        u_hdssp_host_model.xfer(1'b1, 7'h00, 8'hFF, rd, 5);
        repeat (TO_CYC + 100) @(posedge i_clk);
        wr(CFG, 8'h02);
        chk("config", 8'h02, cfg);
    endtask : t_timeout

    task automatic t_power_down;
        wr(CFG, 8'h40);
        chk("power-down config", 8'h40, cfg);
        chk("power-down on", 8'h01, {7'h00, pwr_dn});
        wr(CFG, 8'h43);
        chk("power-down masked", 8'h40, cfg);
        wr(CFG, 8'h02);
        chk("power-down left", 8'h00, cfg);
        chk("power-down off", 8'h00, {7'h00, pwr_dn});
    endtask : t_power_down

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        err_total = 0;
        compares = 0;
        i_reset_n = 1'b0;
        repeat (16) @(posedge i_clk);
        #1 i_reset_n = 1'b1;
        t_reset_state();
        repeat (TO_CYC) @(posedge i_clk);
        t_write_read();
        t_invalid();
        t_soft_reset();
        t_timeout();
        t_power_down();
        tally_and_finish();
    end

    // whole run takes about 0.3 ms; the limit sits at twice that, leaving as much again as margin
    initial begin
        #600000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb_half_duplex_sensor_serial_port

`default_nettype wire
